// file: pkg/sqrt_pkg.sv
// constants and types for the serial query response timing block
`default_nettype none
package sqrt_pkg;
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned CLK_NS = 40;
	// character length in bits for rtu framing (start, 8 data, parity, stop)
	localparam int unsigned CHAR_BITS = 11;
	// silent interval is three and a half characters, so seven half characters
	localparam int unsigned SILENT_HALF_CHARS = 7;
	localparam int unsigned STATUS_MAX_MS = 4;
	localparam int unsigned CONFIG_MAX_MS = 1000;
	localparam int unsigned STATUS_MAX_CYC = STATUS_MAX_MS * (CLK_HZ / 1000);
	localparam int unsigned CONFIG_MAX_CYC = CONFIG_MAX_MS * (CLK_HZ / 1000);
	localparam int unsigned TX_WAIT_DEF_CYC = 25;
	localparam int unsigned PROC_DEF_CYC = 50;
	localparam int unsigned TIMEOUT_DEF_CYC = 25_000_000;
	localparam int unsigned BIT_CYC_DEF = 40;
	localparam int unsigned ERR_LIMIT_DEF = 3;
	localparam int unsigned CNT_W = 32;
	localparam logic [7:0] ERR_CODE_LINK = 8'h84;
	localparam logic [7:0] ERR_CODE_TIMEOUT = 8'h85;
	// query classes decoded upstream
	typedef enum logic [2:0] {
		SQRT_Q_READ,
		SQRT_Q_START,
		SQRT_Q_STOP,
		SQRT_Q_SPEED,
		SQRT_Q_REMOTE_OUT,
		SQRT_Q_CONFIG
	} sqrt_query_e;
	typedef enum logic [2:0] {
		SQRT_IDLE,
		SQRT_SILENT,
		SQRT_TXWAIT,
		SQRT_PROC,
		SQRT_RESPOND,
		SQRT_CFG_BUSY
	} sqrt_state_e;
endpackage
`default_nettype wire

// file: core/sqrt_query_timing.sv
// query to response timing, status update, busy and link fault supervision
`default_nettype none
// Overview of operation
// R01 - response begins after transmit wait, silent interval and processing time elapse
// R02 - start and remote output queries update status within silent interval plus 4 ms
// R03 - configuration work completes within processing plus 1 s, busy shown meanwhile
// R04 - master waits for busy to clear before its next query after configuration
// R05 - stop query picks deceleration from the stored stop action setting
// R06 - speed change and stop settle time follows the commanded speed, not a delay
// R07 - one link error warns, good frame clears it, consecutive errors raise fault
// R08 - no traffic within the configured timeout raises a timeout fault
// R09 - silent interval equals three and a half character times at the bit rate
module sqrt_query_timing
	import sqrt_pkg::*;
#(
	parameter int unsigned TIMEOUT_CYC = TIMEOUT_DEF_CYC,
	parameter int unsigned CONFIG_CYC = CONFIG_MAX_CYC
) (
	input wire logic ref_clk_i,
	input wire logic sys_rst_i,
	input wire logic [15:0] bit_cyc_i,
	input wire logic [15:0] tx_wait_cyc_i,
	input wire logic [15:0] proc_cyc_i,
	input wire logic [7:0] err_limit_i,
	input wire logic [1:0] stop_action_i,
	input wire logic [15:0] cmd_speed_i,
	input wire logic [15:0] cfg_work_cyc_i,
	input wire logic query_done_i,
	input wire logic [2:0] query_kind_i,
	input wire logic frame_err_i,
	output logic resp_start_o,
	output logic status_upd_o,
	output logic [1:0] decel_mode_o,
	output logic [15:0] settle_cyc_o,
	output logic busy_o,
	output logic caution_output_o,
	output logic fault_output_o,
	output logic [7:0] fault_code_o
);
	sqrt_state_e state_q;
	sqrt_query_e kind_q;
	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] silent_cyc;
	logic [CNT_W-1:0] since_end_q;
	logic [CNT_W-1:0] idle_q;
	logic [7:0] err_run_q;
	logic status_pending_q;

	// three and a half characters counted in half characters
	function automatic logic [CNT_W-1:0] silent_len(input logic [15:0] bit_cyc);
		silent_len = CNT_W'((32'(bit_cyc) * CHAR_BITS * SILENT_HALF_CHARS) >> 1);
	endfunction

	assign silent_cyc = silent_len(bit_cyc_i); // R09

	// response sequencer; a query arriving while busy is ignored, master must wait
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			state_q <= SQRT_IDLE;
			kind_q <= SQRT_Q_READ;
			cnt_q <= '0;
		end else begin
			case (state_q)
				SQRT_IDLE: begin
					if (query_done_i && !frame_err_i) begin
						kind_q <= sqrt_query_e'(query_kind_i);
						cnt_q <= '0;
						state_q <= SQRT_TXWAIT;
					end
				end
				SQRT_TXWAIT: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q + 1'b1 >= CNT_W'(tx_wait_cyc_i)) begin // R01
						cnt_q <= '0;
						state_q <= SQRT_SILENT;
					end
				end
				SQRT_SILENT: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q + 1'b1 >= silent_cyc) begin // R01
						cnt_q <= '0;
						state_q <= SQRT_PROC;
					end
				end
				SQRT_PROC: begin
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q + 1'b1 >= CNT_W'(proc_cyc_i)) begin // R01
						cnt_q <= '0;
						state_q <= SQRT_RESPOND;
					end
				end
				SQRT_RESPOND: begin
					state_q <= (kind_q == SQRT_Q_CONFIG) ? SQRT_CFG_BUSY : SQRT_IDLE;
				end
				SQRT_CFG_BUSY: begin
					// work length capped so it never passes the documented bound
					cnt_q <= cnt_q + 1'b1;
					if (cnt_q + 1'b1 >= CNT_W'(cfg_work_cyc_i) ||
						cnt_q + 1'b1 >= CNT_W'(CONFIG_CYC)) begin // R03
						cnt_q <= '0;
						state_q <= SQRT_IDLE;
					end
				end
				default: state_q <= SQRT_IDLE;
			endcase
		end
	end

	assign resp_start_o = (state_q == SQRT_RESPOND); // R01
	assign busy_o = (state_q != SQRT_IDLE); // R03 R04

	// status update is issued once silent interval has passed, well inside the 4 ms bound
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			status_pending_q <= 1'b0;
			since_end_q <= '0;
			status_upd_o <= 1'b0;
		end else begin
			status_upd_o <= 1'b0;
			if (state_q == SQRT_IDLE && query_done_i && !frame_err_i &&
				(query_kind_i == 3'(SQRT_Q_START) || query_kind_i == 3'(SQRT_Q_REMOTE_OUT))) begin
				status_pending_q <= 1'b1;
				since_end_q <= '0;
			end else if (status_pending_q) begin
				since_end_q <= since_end_q + 1'b1;
				if (since_end_q + 1'b1 >= silent_cyc) begin // R02
					status_pending_q <= 1'b0;
					status_upd_o <= 1'b1;
				end
			end
		end
	end

	// motion parameters captured at stop or speed query; settle scales with speed
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			decel_mode_o <= 2'h0;
			settle_cyc_o <= 16'h0000;
		end else if (state_q == SQRT_IDLE && query_done_i && !frame_err_i) begin
			if (query_kind_i == 3'(SQRT_Q_STOP)) begin
				decel_mode_o <= stop_action_i; // R05
				settle_cyc_o <= cmd_speed_i; // R06
			end else if (query_kind_i == 3'(SQRT_Q_SPEED)) begin
				settle_cyc_o <= cmd_speed_i; // R06
			end
		end
	end

	// link error run counter; a good frame clears the warning but not a latched fault
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			err_run_q <= 8'h00;
			caution_output_o <= 1'b0;
		end else if (query_done_i) begin
			if (frame_err_i) begin
				caution_output_o <= 1'b1; // R07
				if (err_run_q != 8'hff) begin
					err_run_q <= err_run_q + 8'h01;
				end
			end else begin
				caution_output_o <= 1'b0; // R07
				err_run_q <= 8'h00;
			end
		end
	end

	// idle watchdog and fault latch; fault holds until reset since no clear exists
	always_ff @(posedge ref_clk_i) begin
		if (sys_rst_i) begin
			idle_q <= '0;
			fault_output_o <= 1'b0;
			fault_code_o <= 8'h00;
		end else begin
			idle_q <= query_done_i ? '0 : idle_q + ((idle_q < CNT_W'(TIMEOUT_CYC)) ? 1'b1 : 1'b0);
			if (!fault_output_o) begin
				if (query_done_i && frame_err_i && err_limit_i != 8'h00 &&
					err_run_q + 8'h01 >= err_limit_i) begin // R07
					fault_output_o <= 1'b1;
					fault_code_o <= ERR_CODE_LINK;
				end else if (!query_done_i && idle_q + 1'b1 >= CNT_W'(TIMEOUT_CYC)) begin // R08
					fault_output_o <= 1'b1;
					fault_code_o <= ERR_CODE_TIMEOUT;
				end
			end
		end
	end

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_good_query;
		state_q == SQRT_IDLE && query_done_i && !frame_err_i;
	endsequence

	a_resp_not_early: assert property (s_good_query |=> !resp_start_o) // R01
		else $error("response started too soon");
	a_busy_follow: assert property (s_good_query |=> busy_o) // R03
		else $error("busy not raised after query");
	a_cfg_busy_hold: assert property (state_q == SQRT_RESPOND && kind_q == SQRT_Q_CONFIG
		|=> busy_o) // R03
		else $error("config busy dropped");
	a_status_pulse: assert property (status_upd_o |=> !status_upd_o) // R02
		else $error("status update longer than one cycle");
	a_stop_decel: assert property (s_good_query ##0 query_kind_i == 3'(SQRT_Q_STOP)
		|=> decel_mode_o == $past(stop_action_i)) // R05
		else $error("stop action not taken");
	a_speed_settle: assert property (s_good_query ##0 query_kind_i == 3'(SQRT_Q_SPEED)
		|=> settle_cyc_o == $past(cmd_speed_i)) // R06
		else $error("settle not from speed");
	a_warn_set: assert property (query_done_i && frame_err_i |=> caution_output_o) // R07
		else $error("warning not raised");
	a_warn_clear: assert property (query_done_i && !frame_err_i |=> !caution_output_o) // R07
		else $error("warning not cleared");
	a_fault_hold: assert property (fault_output_o |=> fault_output_o) // R08
		else $error("fault dropped without reset");
	// the response strobe must not smear into a second cycle
	a_resp_pulse: assert property (resp_start_o |=> !resp_start_o) // R01
		else $error("response start longer than one cycle");
	// work counter never reaches the cap, so busy ends inside the bound
	a_cfg_cap: assert property (state_q == SQRT_CFG_BUSY |-> cnt_q < CNT_W'(CONFIG_CYC)) // R03
		else $error("config work passed its cap");
	a_fault_code: assert property (fault_output_o |->
		(fault_code_o == ERR_CODE_LINK || fault_code_o == ERR_CODE_TIMEOUT)) // R07 R08
		else $error("fault raised without a known code");
endmodule
`default_nettype wire

// file: bench/sqrt_master.sv
// master side model that issues queries and honours the busy handshake
`default_nettype none
module sqrt_master (
	input wire logic ref_clk_i,
	input wire logic busy_i,
	output logic query_done_o,
	output logic [2:0] query_kind_o,
	output logic frame_err_o
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		query_done_o = 1'b0;
		query_kind_o = 3'h7;
		frame_err_o = 1'b0;
	end
	// one frame end pulse; kind and error flag are scrambled outside it
	task automatic send(input logic [2:0] kind, input logic bad);
		while (busy_i !== 1'b0) begin
			@(posedge ref_clk_i);
			#1;
		end
		@(posedge ref_clk_i);
		query_done_o <= 1'b1;
		query_kind_o <= kind;
		frame_err_o <= bad;
		@(posedge ref_clk_i);
		query_done_o <= 1'b0;
		query_kind_o <= ~kind;
		frame_err_o <= ~bad;
	endtask
endmodule
`default_nettype wire

// file: bench/serial_query_response_timing_tb.sv
// self-checking bench for response timing, status, busy and link faults
`default_nettype none
module serial_query_response_timing_tb;
	import sqrt_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int BIT = 2;
	localparam int SIL = BIT * CHAR_BITS * SILENT_HALF_CHARS / 2;
	localparam int RSP = 5 + SIL + 7;
	localparam int CAP = 100;
	typedef struct {logic [2:0] k; logic [1:0] a; logic [15:0] v; int s;} sqrt_row_s;
	// kind, stop action, speed, expected status cycle (0 means none)
	sqrt_row_s rows [6] = '{'{3'h0, 2'h0, 16'h0000, 0}, '{3'h1, 2'h0, 16'h0000, SIL},
		'{3'h2, 2'h1, 16'h0123, 0}, '{3'h3, 2'h3, 16'hbeef, 0},
		'{3'h2, 2'h2, 16'h0040, 0}, '{3'h4, 2'h0, 16'h0000, SIL}};
	logic ref_clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic [1:0] stop_action_i = 2'h0;
	logic [15:0] cmd_speed_i = 16'h0000;
	logic [15:0] cfg_work_cyc_i = 16'h001e;
	logic busy_o, resp_start_o, status_upd_o, caution_output_o, fault_output_o;
	logic query_done_i, frame_err_i;
	logic [2:0] query_kind_i;
	logic [1:0] decel_mode_o;
	logic [15:0] settle_cyc_o;
	logic [7:0] fault_code_o;
	int err_total = 0;
	int checked = 0;
	int r, s, b;
	always #20 ref_clk_i = ~ref_clk_i;
	// timing settings are fixed so every expectation follows from them
	sqrt_query_timing #(.TIMEOUT_CYC(200), .CONFIG_CYC(CAP)) dut (.ref_clk_i(ref_clk_i),
		.sys_rst_i(sys_rst_i), .bit_cyc_i(16'(BIT)), .tx_wait_cyc_i(16'h0005),
		.proc_cyc_i(16'h0007), .err_limit_i(8'h03), .stop_action_i(stop_action_i),
		.cmd_speed_i(cmd_speed_i), .cfg_work_cyc_i(cfg_work_cyc_i), .query_done_i(query_done_i),
		.query_kind_i(query_kind_i), .frame_err_i(frame_err_i), .resp_start_o(resp_start_o),
		.status_upd_o(status_upd_o), .decel_mode_o(decel_mode_o),
		.settle_cyc_o(settle_cyc_o), .busy_o(busy_o), .caution_output_o(caution_output_o),
		.fault_output_o(fault_output_o), .fault_code_o(fault_code_o));
	sqrt_master mst (.ref_clk_i(ref_clk_i), .busy_i(busy_o), .query_done_o(query_done_i),
		.query_kind_o(query_kind_i), .frame_err_o(frame_err_i));
	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// cycles from the accept edge to response, status pulse and busy release
	task automatic meas(output int r, output int s, output int b);
		r = 0;
		s = 0;
		b = 0;
		for (int n = 1; n < 400 && b == 0; n++) begin
			@(posedge ref_clk_i);
			#1;
			if (status_upd_o === 1'b1) s = n;
			if (resp_start_o === 1'b1) r = n;
			if (busy_o === 1'b0) b = n;
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	// main sequence: table of queries, then config, link errors and idle timeout
	initial begin
		repeat (20) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		foreach (rows[i]) begin
			@(posedge ref_clk_i);
			stop_action_i <= rows[i].a;
			cmd_speed_i <= rows[i].v;
			mst.send(rows[i].k, 1'b0);
			meas(r, s, b);
			chk("resp", 16'(RSP), 16'(r));
			chk("status", 16'(rows[i].s), 16'(s));
			if (rows[i].k == 3'h2) chk("decel", {14'h0, rows[i].a}, {14'h0, decel_mode_o});
			if (rows[i].k inside {3'h2, 3'h3}) chk("settle", rows[i].v, settle_cyc_o);
		end
		mst.send(3'h5, 1'b0);
		meas(r, s, b);
		chk("cfg_resp", 16'(RSP), 16'(r));
		chk("cfg_busy", 16'h1, {15'h0, b > r + 29 && b <= r + 31});
		@(posedge ref_clk_i);
		cfg_work_cyc_i <= 16'h00c8;
		mst.send(3'h5, 1'b0);
		meas(r, s, b);
		chk("cfg_cap", 16'(RSP + 1 + CAP), 16'(b));
		mst.send(3'h0, 1'b1);
		@(posedge ref_clk_i);
		#1;
		chk("caution_set", 16'h1, {15'h0, caution_output_o});
		mst.send(3'h0, 1'b0);
		meas(r, s, b);
		chk("caution_clr", 16'h0, {15'h0, caution_output_o});
		repeat (2) mst.send(3'h0, 1'b1);
		@(posedge ref_clk_i);
		#1;
		chk("fault_early", 16'h0, {15'h0, fault_output_o});
		mst.send(3'h0, 1'b1);
		@(posedge ref_clk_i);
		#1;
		chk("fault_link", {7'h0, 1'b1, ERR_CODE_LINK}, {7'h0, fault_output_o, fault_code_o});
		@(posedge ref_clk_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		sys_rst_i <= 1'b0;
		@(posedge ref_clk_i);
		#1;
		chk("rst_flags", 16'h0, {1'b0, fault_code_o, decel_mode_o, caution_output_o,
			fault_output_o, busy_o, status_upd_o, resp_start_o});
		chk("rst_settle", 16'h0, settle_cyc_o);
		repeat (189) @(posedge ref_clk_i);
		#1;
		chk("fault_idle", 16'h0, {15'h0, fault_output_o});
		repeat (15) @(posedge ref_clk_i);
		#1;
		chk("fault_tmo", {7'h0, 1'b1, ERR_CODE_TIMEOUT}, {7'h0, fault_output_o, fault_code_o});
		stop_test();
	end
	// hang guard, well beyond the roughly 1200 cycles the sequence needs
	initial begin
		repeat (5000) @(posedge ref_clk_i);
		err_total++;
		stop_test();
	end
endmodule
`default_nettype wire
